// file: fcc_ctrl.sv
// module: APB-controlled host driving the flash pins
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`default_nettype none
module fcc_ctrl
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // flash pins
  output logic      [FCC_AW-1:0] addr_o,
  input  wire logic [FCC_DW-1:0] dq_i,
  output logic      [FCC_DW-1:0] dq_o,
  output logic                   dq_oe_o,
  output logic                   chip_select_a_n_o,
  output logic                   chip_select_b_n_o,
  output logic                   oe_n_o,
  output logic                   we_n_o,
  output logic                   reset_powerdown_n_o,
  output logic                   byte_n_o,
  output logic                   wp_n_o,
  input  wire logic              activity_output_i
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_reg, rst_n;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0]       ctrl_reg;
  logic [FCC_AW-1:0] faddr_reg;
  logic [FCC_DW-1:0] fwdata_reg;
  logic [FCC_DW-1:0] frdata_reg;
  logic              done_reg;
  logic              act_reg;
  logic [7:0]        wake_reg;
  fcc_state_t        state_reg, state_next;
  fcc_cnt_if         cnt ();

  // apb decode
  wire acc      = psel_i && penable_i;
  wire wr_acc   = acc && pwrite_i;
  wire hit_ctrl = paddr_i == FCC_ADDR_CTRL;
  wire hit_addr = paddr_i == FCC_ADDR_ADDR;
  wire hit_wdat = paddr_i == FCC_ADDR_WDATA;
  wire hit_rdat = paddr_i == FCC_ADDR_RDATA;
  wire hit_stat = paddr_i == FCC_ADDR_STAT;
  wire mapped   = hit_ctrl | hit_addr | hit_wdat | hit_rdat | hit_stat;
  wire busy     = state_reg != FCC_IDLE;
  wire waking   = wake_reg != 8'h00;
  // a new cycle is only launched while idle, awake and out of power-down
  wire go       = wr_acc && hit_ctrl && pwdata_i[FCC_CTRL_GO] && !busy
                  && !waking && !pwdata_i[FCC_CTRL_PDN];
  wire is_wr    = ctrl_reg[FCC_CTRL_WR];
  wire x16      = ctrl_reg[FCC_CTRL_X16];
  wire pdn      = ctrl_reg[FCC_CTRL_PDN];
  wire [31:0] stat_word = {28'h0000000, waking, act_reg, done_reg, busy};
  wire [31:0] rd_mux =
    hit_ctrl ? {ctrl_reg[31:1], 1'b0} :
    hit_addr ? {11'h000, faddr_reg} :
    hit_wdat ? {16'h0000, fwdata_reg} :
    hit_rdat ? {16'h0000, frdata_reg} :
    hit_stat ? stat_word : 32'h0000_0000;

  // control and data registers; the go bit is self clearing
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= FCC_CTRL_RST;
      faddr_reg  <= '0;
      fwdata_reg <= '0;
    end else if (wr_acc && !busy) begin
      if (hit_ctrl) ctrl_reg   <= {pwdata_i[31:1], 1'b0};
      if (hit_addr) faddr_reg  <= pwdata_i[FCC_AW-1:0];
      if (hit_wdat) fwdata_reg <= pwdata_i[FCC_DW-1:0];
    end
  end

  // apb answer: one access cycle, error on unmapped or busy write
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && (!mapped || (pwrite_i && busy));
      prdata_o  <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // ************************************************************
  // reset recovery and activity sampling
  // ************************************************************
  // count the wake time after the reset pin is released
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_reg <= 8'(FCC_WAKE_CYC);
    end else if (pdn) begin
      wake_reg <= 8'(FCC_WAKE_CYC);
    end else if (waking) begin
      wake_reg <= wake_reg - 8'h01;
    end
  end

  // open-drain activity line: low busy, pulled high when floating
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= 1'b1;
    end else begin
      act_reg <= activity_output_i;
    end
  end

  // ************************************************************
  // pin cycle sequencer
  // ************************************************************
  wire expired = cnt.expired;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FCC_IDLE:  if (go) state_next = FCC_SETUP;
      FCC_SETUP: if (expired) state_next = FCC_STRB;
      FCC_STRB:  if (expired) state_next = FCC_HOLD;
      FCC_HOLD:  state_next = FCC_IDLE;
    endcase
  end

  assign cnt.load  = (state_reg == FCC_IDLE && go)
                     || (state_reg == FCC_SETUP && expired);
  assign cnt.count = (state_reg == FCC_IDLE) ? 8'(FCC_SETUP_CYC - 1) :
                     is_wr ? 8'(FCC_WP_CYC - 1) : 8'(FCC_RD_CYC - 1);

  fcc_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .cnt       (cnt.tmr)
  );

  // sequencer state, completion flag and captured read data
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= FCC_IDLE;
      done_reg   <= 1'b0;
      frdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      // completion flag: set wins over a clearing write
      if (state_reg == FCC_HOLD) done_reg <= 1'b1;
      else if (go) done_reg <= 1'b0;
      // read data sampled as the read strobe ends, after a full access
      if (state_reg == FCC_HOLD && !is_wr) begin
        frdata_reg <= x16 ? dq_i : {8'h00, dq_i[7:0]};
      end
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  wire sel    = state_reg != FCC_IDLE;
  wire strobe = state_reg == FCC_STRB;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_o              <= '0;
      dq_o                <= '0;
      dq_oe_o             <= 1'b0;
      chip_select_a_n_o   <= 1'b1;
      chip_select_b_n_o   <= 1'b1;
      oe_n_o              <= 1'b1;
      we_n_o              <= 1'b1;
      reset_powerdown_n_o <= 1'b0;
      byte_n_o            <= 1'b0;
      wp_n_o              <= 1'b0;
    end else begin
      // in x16 the byte select bit is held low
      addr_o   <= x16 ? {faddr_reg[FCC_AW-1:1], 1'b0} : faddr_reg;
      dq_o     <= x16 ? fwdata_reg : {8'h00, fwdata_reg[7:0]};
      dq_oe_o  <= sel && is_wr;
      // both selects low only during a cycle, else standby
      chip_select_a_n_o <= !sel;
      chip_select_b_n_o <= !sel;
      oe_n_o   <= !(strobe && !is_wr);
      // data held stable past the rising write strobe
      we_n_o   <= !(strobe && is_wr);
      reset_powerdown_n_o <= !pdn;
      byte_n_o <= x16;
      wp_n_o   <= ctrl_reg[FCC_CTRL_WPN];
    end
  end

endmodule : fcc_ctrl
`default_nettype wire

// file: fcc_pkg.sv
// package: constants, register map and pin timing for the flash controller
`default_nettype none
package fcc_pkg;
  // ************************************************************
  // own register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] FCC_ADDR_CTRL  = 8'h00;
  localparam logic [7:0] FCC_ADDR_ADDR  = 8'h04;
  localparam logic [7:0] FCC_ADDR_WDATA = 8'h08;
  localparam logic [7:0] FCC_ADDR_RDATA = 8'h0C;
  localparam logic [7:0] FCC_ADDR_STAT  = 8'h10;
  // ctrl fields
  localparam int FCC_CTRL_GO    = 0;  // write 1: start a cycle
  localparam int FCC_CTRL_WR    = 1;  // 1 write, 0 read
  localparam int FCC_CTRL_X16   = 2;  // width select
  localparam int FCC_CTRL_PDN   = 3;  // 1 holds reset pin low
  localparam int FCC_CTRL_WPN   = 4;  // lock pin level
  // status fields
  localparam int FCC_STAT_BUSY  = 0;
  localparam int FCC_STAT_DONE  = 1;
  localparam int FCC_STAT_ACT   = 2;  // activity pin level sampled
  localparam int FCC_STAT_WAKE  = 3;  // reset recovery in progress
  localparam logic [31:0] FCC_CTRL_RST = 32'h0000_0000;
  // ************************************************************
  // timing (10 MHz clock)
  // ************************************************************
  localparam int FCC_CLK_NS     = 100;
  localparam int FCC_T_SETUP_NS = 100;  // address to strobe
  localparam int FCC_T_WP_NS    = 100;  // strobe low width
  localparam int FCC_T_RD_NS    = 120;  // read access time
  localparam int FCC_T_WAKE_NS  = 1000; // reset to write ready
  localparam int FCC_SETUP_CYC  =
    (FCC_T_SETUP_NS + FCC_CLK_NS - 1) / FCC_CLK_NS;
  localparam int FCC_WP_CYC     =
    (FCC_T_WP_NS + FCC_CLK_NS - 1) / FCC_CLK_NS;
  localparam int FCC_RD_CYC     =
    (FCC_T_RD_NS + FCC_CLK_NS - 1) / FCC_CLK_NS;
  localparam int FCC_WAKE_CYC   =
    (FCC_T_WAKE_NS + FCC_CLK_NS - 1) / FCC_CLK_NS;
  localparam int FCC_AW         = 21;
  localparam int FCC_DW         = 16;
  // bus cycle states, gray along setup-strobe-hold-idle
  typedef enum logic [1:0] {
    FCC_IDLE  = 2'b00,
    FCC_SETUP = 2'b01,
    FCC_STRB  = 2'b11,
    FCC_HOLD  = 2'b10
  } fcc_state_t;
endpackage : fcc_pkg
`default_nettype wire

// file: fcc_cnt_if.sv
// interface: start/done link to the cycle timer
`default_nettype none
interface fcc_cnt_if;
  logic       load;
  logic [7:0] count;
  logic       expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : fcc_cnt_if
`default_nettype wire

// file: fcc_timer.sv
// module: down counter that times the pin phases
`default_nettype none
module fcc_timer
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // control link
  fcc_cnt_if.tmr    cnt
);
  logic [7:0] cnt_reg;

  // load on request, count to zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 8'h00;
    end else if (cnt.load) begin
      cnt_reg <= cnt.count;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // expired reads only the count, so load may depend on it without a loop
  assign cnt.expired = (cnt_reg == 8'h00);
endmodule : fcc_timer
`default_nettype wire

// file: fcc_flash_model.sv
// model of the flash device on the far side of the controller
`default_nettype none
module fcc_flash_model
  import fcc_pkg::*;
(
  // pins from the controller
  input  wire logic              clk_sys_i,
  input  wire logic [FCC_AW-1:0] addr_i,
  input  wire logic [FCC_DW-1:0] dq_i,
  input  wire logic              sel_a_n_i,
  input  wire logic              sel_b_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic              rp_n_i,
  input  wire logic              byte_n_i,
  input  wire logic              wp_n_i,
  // pins back to the controller
  output logic      [FCC_DW-1:0] dq_o,
  output logic                   busy_pull_o
);
  logic [FCC_DW-1:0] mem [16];
  logic [FCC_DW-1:0] last;
  logic [FCC_DW-1:0] word;
  logic [3:0]        busy_cnt;
  logic              we_q;
  logic              sel;
  logic              blocked;
  // only block 1 carries a set lock bit
  localparam logic [31:0] LOCKED = 32'h0000_0002;
  assign sel  = !sel_a_n_i && !sel_b_n_i;
  // block number from the top address bits; lock pin high overrides
  assign blocked = LOCKED[addr_i[20:16]] && !wp_n_i;
  assign word = mem[addr_i[4:1]];
  // always read array; idle bus shows the inverse of the last value
  assign dq_o = (sel && !oe_n_i && rp_n_i) ?
    (byte_n_i ? word : {~last[15:8],
     addr_i[0] ? word[15:8] : word[7:0]}) : ~last;
  assign busy_pull_o = (busy_cnt != 4'h0);
  // latch on the rising strobe, nothing taken in power-down
  always @(posedge clk_sys_i) begin
    we_q <= we_n_i;
    last <= dq_o;
    if (!rp_n_i) begin
      busy_cnt <= 4'h0;
    end else if (we_n_i && !we_q && sel && !blocked) begin
      busy_cnt <= 4'h6;
      if (byte_n_i) mem[addr_i[4:1]] <= dq_i;
      else if (addr_i[0]) mem[addr_i[4:1]][15:8] <= dq_i[7:0];
      else mem[addr_i[4:1]][7:0] <= dq_i[7:0];
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
    end
  end
endmodule // fcc_flash_model
`default_nettype wire

// file: fcc_ctrl_checker.sv
// checker: pin and bus assertions on the flash controller
`default_nettype none
module fcc_ctrl_checker
  import fcc_pkg::*;
(
  // ports watched
  input wire logic              clk_sys_i,
  input wire logic              resetn_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pready_o,
  input wire logic [FCC_AW-1:0] addr_o,
  input wire logic [FCC_DW-1:0] dq_o,
  input wire logic              dq_oe_o,
  input wire logic              chip_select_a_n_o,
  input wire logic              chip_select_b_n_o,
  input wire logic              oe_n_o,
  input wire logic              we_n_o,
  input wire logic              reset_powerdown_n_o,
  input wire logic              byte_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // write strobe low for one cycle, then high
  sequence s_strobe;
    !we_n_o ##1 we_n_o;
  endsequence
  a_pready_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  a_select_pair: assert property (
    chip_select_a_n_o == chip_select_b_n_o) else $error("selects differ");
  a_strobe_in_sel: assert property (
    !(we_n_o && oe_n_o) |-> !chip_select_a_n_o)
    else $error("strobe outside select");
  a_write_drive: assert property (!we_n_o |-> dq_oe_o && oe_n_o)
    else $error("write strobe without data");
  a_latch_stable: assert property ($fell(we_n_o) |->
    s_strobe ##0 ($stable(addr_o) && $stable(dq_o)))
    else $error("address or data moved at strobe");
  a_pdn_no_write: assert property (!reset_powerdown_n_o |-> we_n_o)
    else $error("write in power-down");
  a_wake_wait: assert property (
    $rose(reset_powerdown_n_o) |=> we_n_o[*8])
    else $error("write too soon after wake");
  a_x16_addr: assert property (
    byte_n_o && !chip_select_a_n_o |-> !addr_o[0])
    else $error("byte select used in x16");
endmodule // fcc_ctrl_checker
bind fcc_ctrl fcc_ctrl_checker u_chk (.clk_sys_i, .resetn_i, .psel_i,
  .penable_i, .pready_o, .addr_o, .dq_o, .dq_oe_o, .chip_select_a_n_o,
  .chip_select_b_n_o, .oe_n_o, .we_n_o, .reset_powerdown_n_o, .byte_n_o);
`default_nettype wire

// file: fcc_ctrl_bench.sv
// testbench: flash controller driven over APB against a device model
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module fcc_ctrl_bench;
  import fcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, dq_oe, cs_a_n, cs_b_n, oe_n, we_n, rp_n;
  logic byte_n, busy_pull, wp_n;
  logic [FCC_AW-1:0] addr;
  logic [FCC_DW-1:0] dq_c, dq_f;
  int errors = 0, n_checks = 0, cyc = 0;
  fcc_ctrl u_fcc_ctrl (.clk_sys_i, .resetn_i, .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .addr_o(addr), .dq_i(dq_f), .dq_o(dq_c),
    .dq_oe_o(dq_oe), .chip_select_a_n_o(cs_a_n), .chip_select_b_n_o(cs_b_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .reset_powerdown_n_o(rp_n),
    .byte_n_o(byte_n), .wp_n_o(wp_n), .activity_output_i(!busy_pull));
  fcc_flash_model u_fcc_flash_model (.clk_sys_i, .addr_i(addr),
    .dq_i(dq_oe ? dq_c : ~dq_f), .sel_a_n_i(cs_a_n), .sel_b_n_i(cs_b_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n), .byte_n_i(byte_n),
    .wp_n_i(wp_n),
    .dq_o(dq_f), .busy_pull_o(busy_pull));
  initial forever #50 clk_sys_i = ~clk_sys_i;
  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // wait for the answer; only the bench timeout ends this
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // poll status until the given bit equals the given level
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, FCC_ADDR_STAT, 32'h0);
      if (rd[b] === v) break;
    end
    `CHK(rd[b], v, "status poll")
  endtask
  task automatic go(input logic [31:0] c);
    apb(1'b1, FCC_ADDR_CTRL, c | 32'h1);
    poll(FCC_STAT_DONE, 1'b1);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_wr16;
    apb(1'b1, FCC_ADDR_ADDR, 32'h7);
    apb(1'b1, FCC_ADDR_WDATA, 32'hA5C3);
    go(32'h6);
    `CHK(u_fcc_flash_model.mem[3], 16'hA5C3, "x16 write")
    poll(FCC_STAT_ACT, 1'b0);
    poll(FCC_STAT_ACT, 1'b1);
    go(32'h4);
    apb(1'b0, FCC_ADDR_RDATA, 32'h0);
    `CHK(rd, 32'h0000A5C3, "x16 read")
    $display("t_wr16 done");
  endtask
  task automatic t_x8;
    apb(1'b1, FCC_ADDR_ADDR, 32'h6);
    apb(1'b1, FCC_ADDR_WDATA, 32'h5A);
    go(32'h2);
    `CHK(u_fcc_flash_model.mem[3], 16'hA55A, "x8 low byte")
    apb(1'b1, FCC_ADDR_ADDR, 32'h7);
    go(32'h0);
    apb(1'b0, FCC_ADDR_RDATA, 32'h0);
    `CHK(rd, 32'h000000A5, "x8 high byte")
    $display("t_x8 done");
  endtask
  task automatic t_busy;
    apb(1'b1, FCC_ADDR_CTRL, 32'h7);
    apb(1'b1, FCC_ADDR_WDATA, 32'h1234);
    `CHK(err, 1'b1, "write while busy")
    poll(FCC_STAT_BUSY, 1'b0);
    apb(1'b0, FCC_ADDR_WDATA, 32'h0);
    `CHK(rd, 32'h0000005A, "busy write ignored")
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
    $display("t_busy done");
  endtask
  task automatic t_pdn;
    apb(1'b1, FCC_ADDR_CTRL, 32'h8);
    repeat (2) @(posedge clk_sys_i);
    `CHK(rp_n, 1'b0, "reset pin low")
    apb(1'b1, FCC_ADDR_WDATA, 32'hC3C3);
    apb(1'b1, FCC_ADDR_CTRL, 32'hF);
    repeat (8) @(posedge clk_sys_i);
    `CHK(u_fcc_flash_model.mem[3], 16'h005A, "write blocked")
    apb(1'b1, FCC_ADDR_CTRL, 32'h0);
    apb(1'b1, FCC_ADDR_CTRL, 32'h5);
    apb(1'b0, FCC_ADDR_STAT, 32'h0);
    `CHK({rd[FCC_STAT_WAKE], rd[FCC_STAT_BUSY]}, 2'b10, "waking go")
    poll(FCC_STAT_WAKE, 1'b0);
    apb(1'b1, FCC_ADDR_ADDR, 32'h6);
    go(32'h4);
    apb(1'b0, FCC_ADDR_RDATA, 32'h0);
    `CHK(rd, 32'h0000005A, "read after wake")
    $display("t_pdn done");
  endtask
  task automatic t_lock;
    apb(1'b1, FCC_ADDR_ADDR, 32'h10006);
    apb(1'b1, FCC_ADDR_WDATA, 32'h1111);
    go(32'h6);
    `CHK(u_fcc_flash_model.mem[3], 16'h005A, "locked block kept")
    go(32'h16);
    `CHK(u_fcc_flash_model.mem[3], 16'h1111, "lock pin override")
    $display("t_lock done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // timeout watch
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    `CHK({cs_a_n, we_n, rp_n}, 3'b110, "pins in reset")
    resetn_i <= 1'b1;
    // the bus answers only once the internal reset copy has released
    repeat (3) @(posedge clk_sys_i);
    poll(FCC_STAT_WAKE, 1'b0);
    apb(1'b0, FCC_ADDR_CTRL, 32'h0);
    `CHK(rd, FCC_CTRL_RST, "ctrl reset value")
    t_wr16();
    t_x8();
    t_busy();
    t_pdn();
    t_lock();
    summarize();
  end
endmodule // fcc_ctrl_bench
`default_nettype wire
